// file: adc_conversion_control.sv
// Purpose: Register and control logic of a 10-bit converter
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes: Analog path is represented by ports only
`timescale 1ns/1ns
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic breakState,
  input wire logic stopMode,
  input wire logic [9:0] analogIn,
  output logic convIrq,
  output logic [ChanWidth-1:0] channelSel,
  output logic padConnect,
  output logic converterOn
);
  typedef struct packed {
    logic done;
    logic irqEn;
    logic cont;
    logic [ChanWidth-1:0] chan;
    logic [7:0] clkReg;
    logic breakClr;
    logic [9:0] resHold;
    logic lock;
    logic irq;
    logic stopSeen;
    logic wrPend;
    logic rdPend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [ChanWidth-1:0] chanOut;
    logic padOut;
    logic convOut;
  } ctrl_s;
  ctrl_s c_reg, c_next;

  logic seqStart;
  logic seqAbort;
  logic seqBusy;
  logic seqDone;
  logic [9:0] seqResult;
  logic ctrlWrite;
  logic clkWrite;
  logic lowRead;
  logic highRead;
  logic clearOk;
  logic stopAbort;
  logic addrPhase;

  function automatic logic chanActive(input logic [ChanWidth-1:0] ch);
    chanActive = ch != ChanOff;
  endfunction

  function automatic logic chanIsPad(input logic [ChanWidth-1:0] ch);
    chanIsPad = ch <= ChanExtLast || ch == ChanAd8 || ch == ChanAd9;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign addrPhase = hsel && htrans[1] && hready;
  assign ctrlWrite = c_reg.wrPend && c_reg.addr == StatusCtrlOffset;
  assign clkWrite = c_reg.wrPend && c_reg.addr == ClockRegOffset;
  assign lowRead = c_reg.rdPend && c_reg.addr == ResultLowOffset;
  assign highRead = c_reg.rdPend && c_reg.addr == ResultHighOffset;
  // Protected break: accesses leave status alone
  assign clearOk = !breakState || c_reg.breakClr;
  assign stopAbort = stopMode && !c_reg.clkReg[AsyncClkBit] && !c_reg.stopSeen;

  // status/control register writes naming a channel other than ChanOff, and continuous-mode completions without a stop abort, start the sequencer
  assign seqStart = (ctrlWrite && chanActive(hwdata[ChanWidth-1:0])) ||
                    (seqDone && c_reg.cont && chanActive(c_reg.chan) && !stopAbort);
  assign seqAbort = ctrlWrite || clkWrite || stopAbort;

  sar_sequencer #(.CntWidth(6)) seq (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .start(seqStart),
    .abort(seqAbort),
    .longSample(c_reg.clkReg[LongSampleBit]),
    .channel(c_reg.chan),
    .analogIn(analogIn),
    .busy(seqBusy),
    .done(seqDone),
    .result(seqResult)
  );

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  always_comb begin
    c_next = c_reg;
    c_next.wrPend = addrPhase && hwrite;
    c_next.rdPend = addrPhase && !hwrite;
    if (addrPhase) begin
      c_next.addr = haddr[7:0];
    end
    if (ctrlWrite) begin
      c_next.irqEn = hwdata[IrqEnBit];
      c_next.cont = hwdata[ContBit];
      c_next.chan = hwdata[ChanWidth-1:0];
      c_next.stopSeen = 1'b0;
      if (clearOk) begin
        c_next.done = 1'b0;
        c_next.irq = 1'b0;
      end
    end
    if (clkWrite) begin
      c_next.clkReg = hwdata[7:0];
      c_next.cont = 1'b0;
    end
    if (c_reg.wrPend && c_reg.addr == BreakCtrlOffset) begin
      c_next.breakClr = hwdata[BreakClearBit];
    end
    if (lowRead && clearOk) begin
      c_next.done = 1'b0;
      c_next.irq = 1'b0;
      c_next.lock = 1'b0;
    end
    if (highRead && clearOk) begin
      c_next.irq = 1'b0;
      if (c_reg.clkReg[ModeLsb+:2] == Mode10Bit) begin
        c_next.lock = 1'b1;
      end
    end
    if (stopAbort) begin
      c_next.cont = 1'b0;
      c_next.stopSeen = 1'b1;
    end
    if (!stopMode) begin
      c_next.stopSeen = 1'b0;
    end
    // Set wins over any clear in the same cycle
    if (seqDone) begin
      c_next.done = 1'b1;
      c_next.irq = c_reg.irqEn;
      if (!c_reg.lock) begin
        c_next.resHold = seqResult;
      end
    end
    c_next.rdata = 32'h0000_0000;
    if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        StatusCtrlOffset: c_next.rdata = {24'h000000, c_reg.done, c_reg.irqEn,
                                          c_reg.cont, c_reg.chan};
        ResultHighOffset: c_next.rdata = (c_reg.clkReg[ModeLsb+:2] == Mode10Bit) ?
                                         {30'h0, c_reg.resHold[9:8]} :
                                         {24'h000000, c_reg.resHold[9:2]};
        ResultLowOffset: c_next.rdata = {24'h000000, c_reg.resHold[7:0]};
        ClockRegOffset: c_next.rdata = {24'h000000, c_reg.clkReg};
        BreakCtrlOffset: c_next.rdata = {24'h000000, c_reg.breakClr, 7'h00};
        default: c_next.rdata = 32'h0000_0000;
      endcase
    end
    c_next.chanOut = c_next.chan;
    c_next.convOut = seqStart || (seqBusy && !seqAbort && !seqDone);
    c_next.padOut = chanActive(c_next.chan) && chanIsPad(c_next.chan) &&
                    !(stopMode && !c_reg.clkReg[AsyncClkBit]);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c_reg <= '0;
      c_reg.chan <= StatusCtrlReset[ChanWidth-1:0];
      c_reg.chanOut <= StatusCtrlReset[ChanWidth-1:0];
      c_reg.clkReg <= ClockRegReset;
    end else if (clkEn) begin
      c_reg <= c_next;
    end
  end

  assign hrdata = c_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign convIrq = c_reg.irq;
  assign channelSel = c_reg.chanOut;
  assign padConnect = c_reg.padOut;
  assign converterOn = c_reg.convOut;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  done_sets_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && seqDone |=> c_reg.done) else $error("done flag not set");
  write_clears_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && ctrlWrite && !breakState && !seqDone |=> !c_reg.done)
    else $error("write did not clear done");
  break_protects_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && breakState && !c_reg.breakClr && !seqDone |=> c_reg.done == $past(c_reg.done))
    else $error("status changed in protected break");
  irq_follows_en_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && seqDone |=> convIrq == $past(c_reg.irqEn)) else $error("irq mismatch");
  write_starts_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && ctrlWrite && hwdata[4:0] != ChanOff |-> seqStart)
    else $error("write did not start conversion");
  off_no_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && ctrlWrite && hwdata[4:0] == ChanOff |=> !converterOn)
    else $error("all-ones code started conversion");
  stop_cancels_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && stopAbort |=> !c_reg.cont && !seqBusy) else $error("stop did not abort");
  lock_holds_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && c_reg.lock |=> c_reg.resHold == $past(c_reg.resHold))
    else $error("locked result changed");
endmodule

// file: adc_ctrl_pkg.sv
// Purpose: Shared constants for the converter control block
// Assumes: AHB-Lite register access, 32-bit words
// Notes: Register offsets are byte addresses
package adc_ctrl_pkg;
  localparam logic [7:0] StatusCtrlOffset = 8'h00;
  localparam logic [7:0] ResultHighOffset = 8'h04;
  localparam logic [7:0] ResultLowOffset = 8'h08;
  localparam logic [7:0] ClockRegOffset = 8'h0c;
  localparam logic [7:0] BreakCtrlOffset = 8'h10;
  localparam int DoneBit = 7;
  localparam int IrqEnBit = 6;
  localparam int ContBit = 5;
  localparam int ChanWidth = 5;
  localparam logic [4:0] ChanOff = 5'h1f;
  localparam logic [4:0] ChanExtLast = 5'h07;
  localparam logic [4:0] ChanAd8 = 5'h18;
  localparam logic [4:0] ChanAd9 = 5'h19;
  localparam logic [4:0] ChanBandgap = 5'h1a;
  localparam logic [4:0] ChanRefHigh = 5'h1d;
  localparam logic [4:0] ChanRefLow = 5'h1e;
  localparam int ModeLsb = 2;
  localparam logic [1:0] Mode10Bit = 2'h1;
  localparam int LongSampleBit = 4;
  localparam int AsyncClkBit = 7;
  localparam int BreakClearBit = 7;
  localparam logic [7:0] StatusCtrlReset = 8'h1f;
  localparam logic [7:0] ClockRegReset = 8'h00;
  localparam int ConvCycles = 16;
  localparam int ShortSampleCycles = 4;
  localparam int LongSampleCycles = 24;
  typedef enum logic [2:0] {
    ConvIdle = 3'b001,
    ConvSample = 3'b010,
    ConvRun = 3'b100
  } conv_state_e;
endpackage

// file: sar_sequencer.sv
// Purpose: Sample and conversion timing counter
// Assumes: One converter clock per enabled bus cycle
// Notes: Result is analogIn, or zero for channels between ChanExtLast and ChanAd8
`timescale 1ns/1ns
module sar_sequencer
  import adc_ctrl_pkg::*;
#(
  parameter int CntWidth = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic start,
  input wire logic abort,
  input wire logic longSample,
  input wire logic [ChanWidth-1:0] channel,
  input wire logic [9:0] analogIn,
  output logic busy,
  output logic done,
  output logic [9:0] result
);
  typedef struct packed {
    conv_state_e state;
    logic [CntWidth-1:0] cnt;
    logic doneP;
    logic [9:0] res;
  } seq_s;
  seq_s s_reg, s_next;

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.doneP = 1'b0;
    unique case (s_reg.state)
      ConvIdle: begin
        s_next.cnt = '0;
      end
      ConvSample: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == CntWidth'(longSample ? LongSampleCycles - 1 : ShortSampleCycles - 1)) begin
          s_next.state = ConvRun;
          s_next.cnt = '0;
        end
      end
      ConvRun: begin
        s_next.cnt = s_reg.cnt + 1'b1;
        if (s_reg.cnt == CntWidth'(ConvCycles - 1)) begin
          s_next.state = ConvIdle;
          s_next.doneP = 1'b1;
          s_next.res = (channel > ChanExtLast && channel < ChanAd8) ? 10'h000 : analogIn;
        end
      end
    endcase
    if (abort) begin
      s_next.state = ConvIdle;
      s_next.doneP = 1'b0;
    end
    if (start) begin
      s_next.state = ConvSample;
      s_next.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{state: ConvIdle, cnt: '0, doneP: 1'b0, res: 10'h000};
    end else if (clkEn) begin
      s_reg <= s_next;
    end
  end

  assign busy = s_reg.state != ConvIdle;
  assign done = s_reg.doneP;
  assign result = s_reg.res;

  idle_after_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && s_reg.doneP |-> s_reg.state == ConvIdle || $past(start))
    else $error("converter not idle after completion");
endmodule

// file: ahb_sw_model.sv
// Purpose: Software side bus master for the converter block
// Assumes: Single word transfers, slave answers OKAY
// Notes: Waits on hready without limit; the bench watchdog ends a hang
`timescale 1ns/1ns
module ahb_sw_model (
  input wire logic ref_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // ----------------------------------------
  // One transfer, entered just after a rising edge
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // Each read inverts the stale hwdata, so two reads in a row restore the last write data
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

// file: tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero wait state slave, short stand-in conversion timing
// Notes: Scenarios run in sequence after one reset
`timescale 1ns/1ns
module tb;
  import adc_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic breakState = 1'b0;
  logic stopMode = 1'b0;
  logic [9:0] analogIn = 10'h2a5;
  logic hsel, hwrite, hreadyout, hresp, convIrq, padConnect, converterOn;
  logic [31:0] haddr, hwdata, hrdata, rdVal;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] channelSel;
  int errTotal = 0;
  int checkCount = 0;

  always #2 ref_clk = ~ref_clk;

  ahb_sw_model sw (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  adc_conversion_control dut (.ref_clk(ref_clk), .rst(rst), .clkEn(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .breakState(breakState), .stopMode(stopMode), .analogIn(analogIn), .convIrq(convIrq),
    .channelSel(channelSel), .padConnect(padConnect), .converterOn(converterOn));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sw.xfer(1'b1, {24'h0, a}, d, rdVal);
  endtask
  task automatic rd(input logic [7:0] a);
    sw.xfer(1'b0, {24'h0, a}, 32'h0, rdVal);
  endtask
  task automatic waitIrq();
    repeat (200) begin
      @(posedge ref_clk);
      if (convIrq === 1'b1) break;
    end
    chk("irq raised", {31'h0, convIrq}, 32'h1);
  endtask
  task automatic tallyAndFinish();
    if (errTotal == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic scReset();
    chk("chan", {27'h0, channelSel}, 32'h1f);
    chk("pad", {31'h0, padConnect}, 32'h0);
    chk("on", {31'h0, converterOn}, 32'h0);
    rd(StatusCtrlOffset);
    chk("status", rdVal, {24'h0, StatusCtrlReset});
    rd(8'h40);
    chk("unmapped", rdVal, 32'h0);
  endtask
  task automatic scSingle();
    // Converter clock is the bus clock, so sample timing holds
    wr(ClockRegOffset, 32'h04);
    wr(StatusCtrlOffset, 32'h43);
    // Outputs are launched at the data edge, look one edge later
    @(posedge ref_clk);
    chk("chan sel", {27'h0, channelSel}, 32'h3);
    chk("pad on", {31'h0, padConnect}, 32'h1);
    chk("conv on", {31'h0, converterOn}, 32'h1);
    waitIrq();
    rd(StatusCtrlOffset);
    chk("done", rdVal, 32'hc3);
    chk("low power", {31'h0, converterOn}, 32'h0);
    rd(ResultHighOffset);
    chk("high", rdVal, {30'h0, analogIn[9:8]});
    @(posedge ref_clk);
    chk("irq read", {31'h0, convIrq}, 32'h0);
    rd(ResultLowOffset);
    chk("low", rdVal, {24'h0, analogIn[7:0]});
    rd(StatusCtrlOffset);
    chk("done clr", rdVal, 32'h43);
    repeat (80) @(posedge ref_clk);
    chk("one conv", {31'h0, convIrq}, 32'h0);
  endtask
  task automatic scAbort();
    wr(StatusCtrlOffset, 32'h44);
    wr(StatusCtrlOffset, 32'h5f);
    repeat (3) @(posedge ref_clk);
    chk("off", {30'h0, converterOn, padConnect}, 32'h0);
    repeat (80) @(posedge ref_clk);
    chk("no extra", {31'h0, convIrq}, 32'h0);
  endtask
  task automatic scCont();
    wr(StatusCtrlOffset, 32'h62);
    waitIrq();
    rd(ResultLowOffset);
    analogIn <= 10'h15a;
    waitIrq();
    rd(ResultHighOffset);
    chk("cont high", rdVal, 32'h1);
    rd(ResultLowOffset);
    chk("cont low", rdVal, 32'h5a);
    stopMode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("stop", {31'h0, converterOn}, 32'h0);
    stopMode <= 1'b0;
    repeat (80) @(posedge ref_clk);
    chk("no resume", {30'h0, converterOn, convIrq}, 32'h0);
    wr(StatusCtrlOffset, 32'h62);
    wr(ClockRegOffset, 32'h04);
    repeat (3) @(posedge ref_clk);
    chk("clk wr stop", {31'h0, converterOn}, 32'h0);
    repeat (80) @(posedge ref_clk);
    chk("clk wr no irq", {31'h0, convIrq}, 32'h0);
  endtask
  task automatic scBreak();
    wr(StatusCtrlOffset, 32'h41);
    waitIrq();
    breakState <= 1'b1;
    rd(ResultLowOffset);
    rd(StatusCtrlOffset);
    chk("kept", rdVal, 32'hc1);
    chk("irq kept", {31'h0, convIrq}, 32'h1);
    wr(BreakCtrlOffset, 32'h80);
    rd(ResultLowOffset);
    breakState <= 1'b0;
    rd(StatusCtrlOffset);
    chk("cleared", rdVal, 32'h41);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    scReset();
    scSingle();
    scAbort();
    scCont();
    scBreak();
    tallyAndFinish();
  end
  initial begin
    #40000;
    errTotal++;
    tallyAndFinish();
  end
endmodule
